// >>> logic/hpd_host_port.sv
/*
 * Host port with receive FIFO, transmit holding register and six-channel DMA trigger logic.
 * Assumes host pins arrive asynchronously and that memory answers a request by raising
 * i_mem_ready, with read data valid in that same cycle.
 */
`timescale 1ns/1ps
`include "hpd_defines.svh"

// ----------------------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------------------
module hpd_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } hpd_fifo_st_t;
   hpd_fifo_st_t st_q;
   hpd_fifo_st_t st_d;
   logic full;
   logic empty;

   assign empty = (st_q.wp == st_q.rp);
   assign full = (st_q.wp[AW] != st_q.rp[AW]) && (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = st_q.mem[st_q.rp[AW-1:0]];

   always_comb begin
      st_d = st_q;
      if (i_in_valid && !full) begin
         st_d.mem[st_q.wp[AW-1:0]] = i_in_data;
         st_d.wp = st_q.wp + 1'b1;
      end
      if (i_out_ready && !empty) begin
         st_d.rp = st_q.rp + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // hpd_fifo

// ----------------------------------------------------------------------------
// Host port top
// ----------------------------------------------------------------------------
module hpd_host_port
   import hpd_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [15:0] i_host_port_control_reg,
   input wire logic [7:0] i_interface_control_reg,
   input wire logic [`HPD_NUM_CHAN-1:0] i_dma_chan_on,
   input wire logic [`HPD_NUM_CHAN-1:0][4:0] i_dma_request_source_sel,
   input wire logic i_host_chip_select,
   input wire logic i_host_data_strobe,
   input wire logic i_host_read_write_line,
   input wire logic i_host_acknowledge_line,
   input wire logic [`HPD_DATA_W-1:0] i_host_data,
   output logic [`HPD_DATA_W-1:0] o_host_data,
   output logic o_host_data_oe,
   output logic o_host_request_line,
   output hpd_status_t o_host_status_reg,
   output logic [`HPD_NUM_CHAN-1:0] o_dma_trigger,
   output hpd_mem_req_t o_mem_req,
   input wire logic i_mem_ready,
   input wire logic [`HPD_DATA_W-1:0] i_mem_rdata
);
   typedef struct packed {
      logic [`HPD_SYNC_W-1:0] s1;
      logic [`HPD_SYNC_W-1:0] s2;
      logic [`HPD_SYNC_W-1:0] s3;
      logic [`HPD_SYNC_W-1:0] filt;
      logic wr_prev;
      logic rd_prev;
      logic [`HPD_DATA_W-1:0] tx_byte;
      logic tx_full;
      logic data_oe;
      logic req_pin;
      hpd_status_t status;
      logic [`HPD_NUM_CHAN-1:0] trig;
      hpd_mem_req_t mem;
      hpd_state_t state;
   } hpd_st_t;

   hpd_st_t st_q;
   hpd_st_t st_d;
   logic rx_in_valid;
   logic rx_in_ready;
   logic rx_out_valid;
   logic rx_out_ready;
   logic [`HPD_DATA_W-1:0] rx_out_data;

   // Filtered pin levels: bit 11 chip select, 10 strobe, 9 direction, 8 acknowledge.
   logic live;
   logic cs_act;
   logic ds_act;
   logic wr_act;
   logic rd_act;
   logic ack_act;
   logic req_act;

   always_comb begin
      // Multiplexed bus mode is not offered, so selecting it keeps the port quiet.
      live = i_host_port_control_reg[`HPD_CTL_ON_BIT]
         && !i_host_port_control_reg[`HPD_CTL_MUX_BIT];
      cs_act = st_q.filt[11] ~^ i_host_port_control_reg[`HPD_CTL_CS_POL_BIT];
      ds_act = st_q.filt[10] ~^ i_host_port_control_reg[`HPD_CTL_DS_POL_BIT];
      if (i_host_port_control_reg[`HPD_CTL_DUAL_DS_BIT]) begin
         wr_act = ds_act;
         rd_act = st_q.filt[9] ~^ i_host_port_control_reg[`HPD_CTL_DS_POL_BIT];
      end else begin
         wr_act = ds_act && !st_q.filt[9];
         rd_act = ds_act && st_q.filt[9];
      end
      wr_act = wr_act && live && cs_act;
      rd_act = rd_act && live && cs_act;
      ack_act = live && (st_q.filt[8] ~^ i_host_port_control_reg[`HPD_CTL_ACK_POL_BIT]);
      if (i_interface_control_reg[`HPD_ICR_DUAL_REQ_BIT]) begin
         req_act = live && st_q.tx_full;
      end else begin
         req_act = live && (st_q.tx_full || rx_in_ready);
      end
   end

   assign rx_in_valid = wr_act && !st_q.wr_prev;
   assign rx_out_ready = (st_q.state == HPD_RX_WAIT) && i_mem_ready;

   hpd_fifo #(
      .W(`HPD_DATA_W),
      .D(`HPD_FIFO_DEPTH)
   ) u_rx_fifo (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(rx_in_valid),
      .o_in_ready(rx_in_ready),
      .i_in_data(st_q.filt[`HPD_DATA_W-1:0]),
      .o_out_valid(rx_out_valid),
      .i_out_ready(rx_out_ready),
      .o_out_data(rx_out_data)
   );

   always_comb begin
      logic found;
      found = 1'b0;
      st_d = st_q;
      st_d.s1 = {i_host_chip_select, i_host_data_strobe, i_host_read_write_line,
         i_host_acknowledge_line, i_host_data};
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int b = 0; b < `HPD_SYNC_W; b++) begin
         if (st_q.s2[b] == st_q.s3[b]) begin
            st_d.filt[b] = st_q.s3[b];
         end
      end
      st_d.wr_prev = wr_act;
      st_d.rd_prev = rd_act;
      st_d.data_oe = rd_act;
      // The byte is released once the host ends its read strobe.
      if (st_q.rd_prev && !rd_act) begin
         st_d.tx_full = 1'b0;
      end
      // Acknowledge only reports a level; it never paces transfers.
      st_d.status.ack_seen = ack_act;
      if (rx_in_valid && !rx_in_ready) begin
         st_d.status.overrun = 1'b1;
      end
      st_d.req_pin = req_act ? i_host_port_control_reg[`HPD_CTL_REQ_POL_BIT]
         : !i_host_port_control_reg[`HPD_CTL_REQ_POL_BIT];
      st_d.trig = '0;
      case (st_q.state)
         HPD_IDLE: begin
            for (int c = 0; c < `HPD_NUM_CHAN; c++) begin
               if (!found && i_dma_chan_on[c]) begin
                  if (i_dma_request_source_sel[c] == `HPD_DRS_HOST_RX
                     && st_q.status.receive_full_flag) begin
                     found = 1'b1;
                     st_d.trig[c] = 1'b1;
                     st_d.mem = '{valid: 1'b1, write: 1'b1, chan: 3'(c), data: rx_out_data};
                     st_d.state = HPD_RX_WAIT;
                  end else if (i_dma_request_source_sel[c] == `HPD_DRS_HOST_TX
                     && st_q.status.transmit_empty_flag && !rd_act) begin
                     found = 1'b1;
                     st_d.trig[c] = 1'b1;
                     st_d.mem = '{valid: 1'b1, write: 1'b0, chan: 3'(c),
                        data: `HPD_RST_BYTE};
                     st_d.state = HPD_TX_WAIT;
                  end
               end
            end
         end
         HPD_RX_WAIT: begin
            if (i_mem_ready) begin
               st_d.mem.valid = 1'b0;
               st_d.state = HPD_IDLE;
            end
         end
         HPD_TX_WAIT: begin
            if (i_mem_ready) begin
               st_d.mem.valid = 1'b0;
               st_d.tx_byte = i_mem_rdata;
               st_d.tx_full = 1'b1;
               st_d.state = HPD_IDLE;
            end
         end
         default: begin
            st_d.mem.valid = 1'b0;
            st_d.state = HPD_IDLE;
         end
      endcase
      // The receive flag follows state one cycle late, so a fresh pop is not seen as new data.
      st_d.status.receive_full_flag = rx_out_valid && !rx_out_ready
         && (st_q.state != HPD_RX_WAIT);
      st_d.status.transmit_empty_flag = !st_d.tx_full && (st_d.state != HPD_TX_WAIT);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         st_q <= '0;
         st_q.req_pin <= 1'b1;
         st_q.state <= HPD_IDLE;
         st_q.tx_byte <= `HPD_RST_BYTE;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_host_data = st_q.tx_byte;
   assign o_host_data_oe = st_q.data_oe;
   assign o_host_request_line = st_q.req_pin;
   assign o_host_status_reg = st_q.status;
   assign o_dma_trigger = st_q.trig;
   assign o_mem_req = st_q.mem;
endmodule // hpd_host_port

// >>> pkg/hpd_defines.svh
/*
 * Constants of the host port block: control bit positions, request source codes, sizes.
 * Assumes inclusion by the package and the design file under its bare name.
 */
// Notes on behaviour
// - A 0 in control bit 12 selects one data strobe plus a read/write direction line.
// - Control bit 9 sets the data strobe polarity, and 0 makes it active low.
// - A 0 in interface control bit 2 makes one request line signal both receive and transmit needs.
// - Control bits 14 and 15 set request and acknowledge polarity, and 0 makes each active low.
// - A six-channel DMA controller moves data between internal memory and the host port.
// - Each channel has a five-bit request source field, and two codes of it pick the host port, one for receive and one for transmit.
// - A channel set to the host port is triggered by the receive-full or transmit-empty flag.
// - There is no request and acknowledge handshake that lets an outside DMA stream data.
// - The port works only while control bit 6 is 1, and there is no enable pin; the DMA triggers and memory requests still run while bit 6 is 0.
// - A 0 in control bit 11 selects the non-multiplexed host bus with separate address lines; the port has no address inputs.
// - Control bit 13 sets the chip select polarity, and 0 makes it active low.
`ifndef HPD_DEFINES_SVH
`define HPD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------------
`define HPD_CTL_ON_BIT 6
`define HPD_CTL_DS_POL_BIT 9
`define HPD_CTL_MUX_BIT 11
`define HPD_CTL_DUAL_DS_BIT 12
`define HPD_CTL_CS_POL_BIT 13
`define HPD_CTL_REQ_POL_BIT 14
`define HPD_CTL_ACK_POL_BIT 15
`define HPD_ICR_DUAL_REQ_BIT 2

// ----------------------------------------------------------------------------
// Request source codes and sizes
// ----------------------------------------------------------------------------
`define HPD_DRS_HOST_RX 5'h12
`define HPD_DRS_HOST_TX 5'h13
`define HPD_NUM_CHAN 6
`define HPD_DATA_W 8
`define HPD_FIFO_DEPTH 4
`define HPD_SYNC_W 12
`define HPD_RST_BYTE 8'h00

`endif

// >>> pkg/hpd_pkg.sv
/*
 * Types of the host port block.
 * Assumes the defines header is on the include path.
 */
`include "hpd_defines.svh"

package hpd_pkg;

   typedef enum logic [2:0] {
      HPD_IDLE = 3'h1,
      HPD_RX_WAIT = 3'h2,
      HPD_TX_WAIT = 3'h4
   } hpd_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [2:0] chan;
      logic [`HPD_DATA_W-1:0] data;
   } hpd_mem_req_t;

   typedef struct packed {
      logic ack_seen;
      logic overrun;
      logic transmit_empty_flag;
      logic receive_full_flag;
   } hpd_status_t;

endpackage

// >>> sim/host_port_strobe_dma_config_tb.sv
/* Self-checking bench of the host port; memory is answered here.
   Assumes design, checker and host model are compiled first. */
`timescale 1ns/1ps
module host_port_strobe_dma_config_tb;
   import hpd_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] ctl = 16'h0000;
   logic [7:0] interface_control_reg = 8'h00;
   logic [5:0] on = 6'h00;
   logic [5:0][4:0] sel = '0;
   logic ready = 1'b0;
   logic stall = 1'b0;
   logic [7:0] rdata = 8'h3c;
   logic cs, ds, rw, ack, oe, req;
   logic [7:0] hd, od, b;
   logic [5:0] trig;
   logic [2:0] lc;
   hpd_status_t st;
   hpd_mem_req_t mr;
   logic [7:0] wq[$];
   int error_cnt = 0;
   int n_checks = 0;
   always #12.5 clk = ~clk;
   hpd_host_port dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_host_port_control_reg(ctl),
      .i_interface_control_reg(interface_control_reg), .i_dma_chan_on(on), .i_dma_request_source_sel(sel),
      .i_host_chip_select(cs), .i_host_data_strobe(ds), .i_host_read_write_line(rw),
      .i_host_acknowledge_line(ack), .i_host_data(hd), .o_host_data(od), .o_host_data_oe(oe),
      .o_host_request_line(req), .o_host_status_reg(st), .o_dma_trigger(trig), .o_mem_req(mr),
      .i_mem_ready(ready), .i_mem_rdata(rdata));
   hpd_host_model host_u (.i_ref_clk(clk), .i_ctl(ctl), .i_oe(oe), .i_data(od), .o_cs(cs),
      .o_ds(ds), .o_rw(rw), .o_ack(ack), .o_data(hd));
   always @(negedge clk) ready <= mr.valid && !ready && !stall;
   always @(posedge clk) if (mr.valid && ready) begin
      lc = mr.chan;
      if (mr.write) wq.push_back(mr.data);
   end
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic cfg(input logic [15:0] c, input logic [5:0] o);
      ctl = c;
      on = o;
      wq.delete();
      wt(8);
   endtask
   task automatic wq_wait(input int k);
      for (int i = 0; i < 400 && wq.size() < k; i++) @(negedge clk);
   endtask
   task automatic t_reset();
      chk("req_rst", req, 1'b1);
      chk("oe_rst", oe, 1'b0);
      chk("trig_rst", trig, 6'h00);
   endtask
   task automatic t_off();
      host_u.wr(8'h5a);
      chk("req_off", req, 1'b1);
      chk("rx_off", st.receive_full_flag, 1'b0);
   endtask
   task automatic t_wr();
      sel[2] = 5'h12;
      cfg(16'h0040, 6'h04);
      host_u.wr(8'ha5);
      wq_wait(1);
      wt(3);
      chk("wdata", wq[0], 8'ha5);
      chk("wchan", lc, 3'h2);
      chk("rx_drained", st.receive_full_flag, 1'b0);
   endtask
   task automatic t_rd();
      sel[4] = 5'h13;
      interface_control_reg = 8'h04;
      cfg(16'h0040, 6'h10);
      on = 6'h00;
      chk("req_full", req, 1'b0);
      chk("tx_loaded", st.transmit_empty_flag, 1'b0);
      host_u.rd(b);
      chk("rdata", b, 8'h3c);
      chk("tx_empty", st.transmit_empty_flag, 1'b1);
      chk("req_dual", req, 1'b1);
      interface_control_reg = 8'h00;
      wt(3);
      chk("req_single", req, 1'b0);
   endtask
   task automatic t_pol();
      sel[5] = 5'h12;
      // Polarities change only while the port is off, so lagging pins cannot fake a strobe.
      cfg(16'he200, 6'h20);
      cfg(16'he240, 6'h20);
      host_u.wr(8'hc3);
      wq_wait(1);
      chk("pol_data", wq[0], 8'hc3);
      chk("pol_req", req, 1'b1);
      host_u.set_ack(1'b1);
      wt(6);
      chk("ack_seen", st.ack_seen, 1'b1);
      ctl = 16'he200;
      wt(6);
      chk("pol_off", req, 1'b0);
      chk("ack_off", st.ack_seen, 1'b0);
      host_u.set_ack(1'b0);
   endtask
   task automatic t_dual();
      cfg(16'h1000, 6'h00);
      cfg(16'h1040, 6'h12);
      host_u.wr(8'h69);
      wq_wait(1);
      chk("dual_wdata", wq[0], 8'h69);
      host_u.rd(b);
      chk("dual_rdata", b, 8'h3c);
   endtask
   task automatic t_mux();
      cfg(16'h0840, 6'h04);
      host_u.wr(8'h77);
      wt(10);
      chk("mux_drop", 16'(wq.size()), 16'h0000);
      chk("mux_req", req, 1'b1);
   endtask
   task automatic t_fifo();
      sel[1] = 5'h12;
      cfg(16'h0040, 6'h00);
      for (int i = 0; i < 5; i++) host_u.wr(8'h10 + i[7:0]);
      chk("overrun", st.overrun, 1'b1);
      stall = 1'b1;
      on = 6'h02;
      wt(12);
      stall = 1'b0;
      wq_wait(4);
      for (int i = 0; i < 4; i++) chk("fifo", wq[i], 8'h10 + i[7:0]);
   endtask
   task automatic close_out();
      $display("Checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      wt(20);
      t_reset();
      rst = 1'b0;
      wt(2);
      t_off();
      t_wr();
      t_rd();
      t_pol();
      t_mux();
      t_fifo();
      t_dual();
      close_out();
   end
   // The tests take about three hundred cycles; this limit is far beyond that.
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      close_out();
   end
endmodule // host_port_strobe_dma_config_tb

// >>> sim/hpd_host_model.sv
/* Host processor model driving the port pins with polarities taken from control.
   Assumes the bench calls one task at a time and tasks start at a falling edge. */
`timescale 1ns/1ps
module hpd_host_model (
   input wire logic i_ref_clk,
   input wire logic [15:0] i_ctl,
   input wire logic i_oe,
   input wire logic [7:0] i_data,
   output logic o_cs,
   output logic o_ds,
   output logic o_rw,
   output logic o_ack,
   output logic [7:0] o_data
);
   logic cs_a = 1'b0;
   logic ds_a = 1'b0;
   logic rw_a = 1'b0;
   logic ack_a = 1'b0;
   initial o_data = 8'h00;
   assign o_cs = ~(cs_a ^ i_ctl[13]);
   assign o_ds = ~(ds_a ^ i_ctl[9]);
   // With two strobes the direction pin becomes the read strobe and takes the strobe polarity.
   assign o_rw = i_ctl[12] ? ~(rw_a ^ i_ctl[9]) : rw_a;
   // Acknowledge moves only when the bench asks, since no external DMA handshake exists.
   assign o_ack = ~(ack_a ^ i_ctl[15]);
   task automatic set_ack(input logic a);
      ack_a = a;
   endtask
   task automatic wr(input logic [7:0] b);
      cs_a = 1'b1;
      rw_a = 1'b0;
      o_data = b;
      ds_a = 1'b1;
      repeat (6) @(negedge i_ref_clk);
      ds_a = 1'b0;
      cs_a = 1'b0;
      // Released data is not left looking valid.
      o_data = ~b;
      repeat (6) @(negedge i_ref_clk);
   endtask
   task automatic rd(output logic [7:0] b);
      cs_a = 1'b1;
      rw_a = 1'b1;
      // A two-strobe read uses the direction pin alone, or it would also look like a write.
      ds_a = !i_ctl[12];
      for (int n = 0; n < 20 && i_oe !== 1'b1; n++) @(negedge i_ref_clk);
      b = i_data;
      ds_a = 1'b0;
      cs_a = 1'b0;
      rw_a = 1'b0;
      repeat (6) @(negedge i_ref_clk);
   endtask
endmodule // hpd_host_model

// >>> sim/hpd_host_port_assertions.sv
/* Checker of the host port top: request, enable and DMA trigger relations.
   Assumes binding to hpd_host_port and control inputs held steady within a test. */
`timescale 1ns/1ps
`include "hpd_defines.svh"
module hpd_host_port_assertions
   import hpd_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [15:0] i_host_port_control_reg,
   input wire logic i_mem_ready,
   input wire logic o_host_request_line,
   input wire logic o_host_data_oe,
   input wire hpd_status_t o_host_status_reg,
   input wire logic [`HPD_NUM_CHAN-1:0] o_dma_trigger,
   input wire hpd_mem_req_t o_mem_req
);
   wire logic [15:0] c = i_host_port_control_reg;
   wire logic [`HPD_NUM_CHAN-1:0] t = o_dma_trigger;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   // Four steady cycles give the output flops time to follow a new setting.
   sequence s_off; (!c[6] && $stable(c))[*4]; endsequence
   sequence s_mux; (c[11] && $stable(c))[*4]; endsequence
   sequence s_wait; o_mem_req.valid && !i_mem_ready; endsequence
   property p_req_off; s_off |-> o_host_request_line == ~c[14]; endproperty
   a_req_off: assert property (p_req_off) else $error("request active while off");
   property p_oe_off; s_off |-> !o_host_data_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("data driven while off");
   property p_mux_off; s_mux |-> o_host_request_line == ~c[14] && !o_host_data_oe; endproperty
   a_mux_off: assert property (p_mux_off) else $error("port live in mux mode");
   property p_trig_one; t != 0 |-> $onehot(t) && o_mem_req.valid; endproperty
   a_trig_one: assert property (p_trig_one) else $error("bad trigger pulse");
   property p_trig_chan; t != 0 |-> t[o_mem_req.chan]; endproperty
   a_trig_chan: assert property (p_trig_chan) else $error("channel mismatch");
   property p_trig_flag;
      t != 0 |-> $past(o_host_status_reg.receive_full_flag
                       || o_host_status_reg.transmit_empty_flag);
   endproperty
   a_trig_flag: assert property (p_trig_flag) else $error("trigger without flag");
   property p_mem_hold; s_wait |=> o_mem_req.valid && $stable(o_mem_req); endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("request not held");
   property p_mem_done; o_mem_req.valid && i_mem_ready |=> !o_mem_req.valid; endproperty
   a_mem_done: assert property (p_mem_done) else $error("request not released");
endmodule // hpd_host_port_assertions

bind hpd_host_port hpd_host_port_assertions chk_u (.i_ref_clk, .i_sys_rst,
   .i_host_port_control_reg, .i_mem_ready, .o_host_request_line, .o_host_data_oe,
   .o_host_status_reg, .o_dma_trigger, .o_mem_req);
